// ===== hdl/lcdtg_pkg.sv
// constants, field layout and register map of the panel timing and contrast block
//----------------------------------------------------------------
// Function
// - line sync stays active for hsync_width plus one pixel clocks.
// - frame sync stays active for vsync_width plus one lines.
// - frame ends with vertical_front_porch plus one blank lines.
// - frame begins with exactly vertical_back_porch blank lines.
// - line ends with horizontal_front_porch plus one pixel clocks.
// - line begins with horizontal_back_porch plus one pixel clocks.
// - active lines per frame equal active_row_count plus one.
// - active pixels per line equal active_pixel_count plus one.
// - sync polarity bit 0 gives active high, 1 gives active low.
// - vsync_start_align 0 starts frame sync at hsync second edge, 1 first.
// - vsync_end_align 0 ends frame sync at hsync second edge, 1 first.
// - panel_power_polarity 0 gives active high power, 1 active low.
// - dither bit 1 dithers output pixels, 0 bypasses dithering.
// - panel_power_align 0 asserts power at hsync second edge, 1 freely.
// - depth field 0,1,2,3 selects 12, 16, 18, 24 bits per pixel.
// - vsync_setup 1 starts frame sync one pixel clock earlier.
// - vsync_hold 1 keeps frame sync one pixel clock longer.
// - power_guard_frames frames pass before power on and after power off.
// - contrast_prescale 0..6 divides contrast clock by 1..64.
// - contrast_polarity 1 high below compare, 0 gives low pulses.
// - contrast counter compared with eight-bit compare in bits 15:8.
// - pixel clock is system clock divided by divider plus two.
// - contrast clock source 0 slow clock, 1 system clock.
// - sync off request takes effect only at the end of a frame.
//----------------------------------------------------------------
package lcdtg_pkg;
   //----------------------------------------------------------------
   // register byte addresses
   //----------------------------------------------------------------
   localparam logic [31:0] ADDR_CLOCK_CFG   = 32'hF8038000;
   localparam logic [31:0] ADDR_SYNC_WIDTH  = 32'hF8038004;
   localparam logic [31:0] ADDR_VPORCH      = 32'hF8038008;
   localparam logic [31:0] ADDR_HPORCH      = 32'hF803800C;
   localparam logic [31:0] ADDR_AREA        = 32'hF8038010;
   localparam logic [31:0] ADDR_POLOUT      = 32'hF8038014;
   localparam logic [31:0] ADDR_PWM         = 32'hF8038018;
   localparam logic [31:0] ADDR_CTRL        = 32'hF8038020;
   localparam logic [31:0] ADDR_STATUS      = 32'hF8038028;
   //----------------------------------------------------------------
   // writable bits, reserved bits read zero
   //----------------------------------------------------------------
   localparam logic [31:0] MASK_CLOCK_CFG   = 32'h00FF0008;
   localparam logic [31:0] MASK_SYNC_WIDTH  = 32'h003F00FF;
   localparam logic [31:0] MASK_VPORCH      = 32'h003F003F;
   localparam logic [31:0] MASK_HPORCH      = 32'h00FF00FF;
   localparam logic [31:0] MASK_AREA        = 32'h07FF07FF;
   localparam logic [31:0] MASK_POLOUT      = 32'h001F33DF;
   localparam logic [31:0] MASK_PWM         = 32'h0000FF17;
   localparam logic [2:0]  MASK_CTRL        = 3'h7;
   //----------------------------------------------------------------
   // field positions
   //----------------------------------------------------------------
   localparam int F_DIV      = 16;
   localparam int F_PWMSRC   = 3;
   localparam int F_HSW      = 0;
   localparam int F_VSW      = 16;
   localparam int F_VFP      = 0;
   localparam int F_VBP      = 16;
   localparam int F_HFP      = 0;
   localparam int F_HBP      = 16;
   localparam int F_PPL      = 0;
   localparam int F_RPF      = 16;
   localparam int F_HSYNC_POLARITY    = 0;
   localparam int F_VSYNC_POLARITY    = 1;
   localparam int F_VSALS    = 2;
   localparam int F_VSALE    = 3;
   localparam int F_PWRPOL   = 4;
   localparam int F_DITHER   = 6;
   localparam int F_PWRALIGN = 7;
   localparam int F_DEPTH    = 8;
   localparam int F_VSSU     = 12;
   localparam int F_VSHO     = 13;
   localparam int F_GUARD    = 16;
   localparam int F_PS       = 0;
   localparam int F_CONTRAST_POLARITY   = 4;
   localparam int F_CVAL     = 8;
   localparam int C_SYNC     = 0;
   localparam int C_POWER    = 1;
   localparam int C_PWM      = 2;
   //----------------------------------------------------------------
   // fixed figures
   //----------------------------------------------------------------
   localparam logic [11:0] H_EXTRA   = 12'h004;
   localparam logic [11:0] V_EXTRA   = 12'h003;
   localparam logic [8:0]  DIV_EXTRA = 9'h002;
   localparam logic [2:0]  PS_MAX    = 3'h6;
   localparam logic [1:0]  DEPTH_12  = 2'h0;
   localparam logic [1:0]  DEPTH_16  = 2'h1;
   localparam logic [1:0]  DEPTH_18  = 2'h2;
   localparam logic [1:0]  DEPTH_24  = 2'h3;
   typedef enum logic [1:0] {PWR_OFF, PWR_UP, PWR_ON, PWR_DOWN} lcdtg_pwr_e;
endpackage

// ===== hdl/lcdtg_top.sv
// panel timing generator with display power sequencing and contrast pwm
`timescale 1ns/1ps
`default_nettype none
module lcdtg_top
   import lcdtg_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic        slow_clk_in,
   input  wire logic [23:0] pixel_in,
   output logic             pixel_clock_out,
   output logic             line_sync_out,
   output logic             frame_sync_out,
   output logic             data_enable_out,
   output logic      [23:0] pixel_data_out,
   output logic             panel_power_out,
   output logic             contrast_pwm_out
);

   //----------------------------------------------------------------
   // state
   //----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] clock_cfg;
      logic [31:0] sync_width;
      logic [31:0] vporch;
      logic [31:0] hporch;
      logic [31:0] area;
      logic [31:0] polout;
      logic [31:0] pwm;
      logic [2:0]  ctrl;
      logic [31:0] rdata;
      logic [8:0]  div_cnt;
      logic        pclk;
      logic [11:0] hpos;
      logic [11:0] vpos;
      logic        run;
      logic        vs_act;
      logic        hs_o;
      logic        vs_o;
      logic        de_o;
      logic [23:0] pix_o;
      lcdtg_pwr_e  pwr_st;
      logic [4:0]  guard_cnt;
      logic        pwr_act;
      logic        pwr_o;
      logic        slow_q;
      logic [5:0]  pre_cnt;
      logic [7:0]  pwm_cnt;
      logic        pwm_o;
   } lcdtg_state_s;

   lcdtg_state_s st_r;
   lcdtg_state_s st_nxt;

   //----------------------------------------------------------------
   // dither helper
   //----------------------------------------------------------------
   // adds a 2x2 ordered pattern below the kept bits, saturating at full scale
   function automatic logic [7:0] lcdtg_dith(input logic [7:0] c,
                                             input logic [1:0] d,
                                             input int         k);
      logic [8:0] s;
      s = {1'b0, c} + 9'({7'h00, d} << (k - 2));
      return s[8] ? 8'hFF : s[7:0];
   endfunction

   //----------------------------------------------------------------
   // field views
   //----------------------------------------------------------------
   logic [7:0]  divider;
   logic        pwm_src;
   logic [7:0]  hsw;
   logic [5:0]  vsw;
   logic [5:0]  vfp;
   logic [5:0]  vbp;
   logic [7:0]  hfp;
   logic [7:0]  hbp;
   logic [10:0] active_pixel_count;
   logic [10:0] active_row_count;
   logic [1:0]  depth;
   logic [4:0]  guard;
   logic [2:0]  ps;
   logic [7:0]  cval;

   assign divider = st_r.clock_cfg[F_DIV +: 8];
   assign pwm_src = st_r.clock_cfg[F_PWMSRC];
   assign hsw     = st_r.sync_width[F_HSW +: 8];
   assign vsw     = st_r.sync_width[F_VSW +: 6];
   assign vfp     = st_r.vporch[F_VFP +: 6];
   assign vbp     = st_r.vporch[F_VBP +: 6];
   assign hfp     = st_r.hporch[F_HFP +: 8];
   assign hbp     = st_r.hporch[F_HBP +: 8];
   assign active_pixel_count     = st_r.area[F_PPL +: 11];
   assign active_row_count     = st_r.area[F_RPF +: 11];
   assign depth   = st_r.polout[F_DEPTH +: 2];
   assign guard   = st_r.polout[F_GUARD +: 5];
   assign ps      = st_r.pwm[F_PS +: 3];
   assign cval    = st_r.pwm[F_CVAL +: 8];

   //----------------------------------------------------------------
   // geometry
   //----------------------------------------------------------------
   logic [11:0] htot;
   logic [11:0] vtot;
   logic [11:0] h_act0;
   logic [11:0] h_act1;
   logic [11:0] v_act0;
   logic [11:0] v_act1;
   logic [11:0] h_edge2;

   always_comb
   begin
      htot    = 12'(hsw) + 12'(hbp) + 12'(active_pixel_count) + 12'(hfp) + H_EXTRA;
      vtot    = 12'(vsw) + 12'(vbp) + 12'(active_row_count) + 12'(vfp) + V_EXTRA;
      h_act0  = 12'(hsw) + 12'(hbp) + 12'h002;
      h_act1  = h_act0 + 12'(active_pixel_count);
      v_act0  = 12'(vsw) + 12'(vbp) + 12'h001;
      v_act1  = v_act0 + 12'(active_row_count);
      h_edge2 = 12'(hsw) + 12'h001;
   end

   //----------------------------------------------------------------
   // next state
   //----------------------------------------------------------------
   logic        tick;
   logic        h_last;
   logic        frame_end;
   logic [11:0] h_n;
   logic [11:0] v_n;
   logic        run_n;
   logic        vs_start;
   logic        vs_end;
   logic [11:0] vs_end_pos;
   logic        frame_start;
   logic        edge2_now;
   logic [1:0]  dpat;
   logic [7:0]  rr;
   logic [7:0]  gg;
   logic [7:0]  bb;
   logic [23:0] fmt;
   logic        pwm_tick_src;
   logic [5:0]  pre_mask;
   logic [2:0]  ps_eff;
   logic        below;
   logic [31:0] rd_val;

   always_comb
   begin
      st_nxt = st_r;

      //----------------------------------------------------------------
      // register writes
      //----------------------------------------------------------------
      if (wr_in)
      begin
         unique case (addr_in)
            ADDR_CLOCK_CFG:  st_nxt.clock_cfg  = wdata_in & MASK_CLOCK_CFG;
            ADDR_SYNC_WIDTH: st_nxt.sync_width = wdata_in & MASK_SYNC_WIDTH;
            ADDR_VPORCH:     st_nxt.vporch     = wdata_in & MASK_VPORCH;
            ADDR_HPORCH:     st_nxt.hporch     = wdata_in & MASK_HPORCH;
            ADDR_AREA:       st_nxt.area       = wdata_in & MASK_AREA;
            ADDR_POLOUT:     st_nxt.polout     = wdata_in & MASK_POLOUT;
            ADDR_PWM:        st_nxt.pwm        = wdata_in & MASK_PWM;
            ADDR_CTRL:       st_nxt.ctrl       = wdata_in[2:0] & MASK_CTRL;
            default:         st_nxt.ctrl       = st_r.ctrl;
         endcase
      end

      //----------------------------------------------------------------
      // register reads, data only in the cycle after the strobe
      //----------------------------------------------------------------
      unique case (addr_in)
         ADDR_CLOCK_CFG:  rd_val = st_r.clock_cfg;
         ADDR_SYNC_WIDTH: rd_val = st_r.sync_width;
         ADDR_VPORCH:     rd_val = st_r.vporch;
         ADDR_HPORCH:     rd_val = st_r.hporch;
         ADDR_AREA:       rd_val = st_r.area;
         ADDR_POLOUT:     rd_val = st_r.polout;
         ADDR_PWM:        rd_val = st_r.pwm;
         ADDR_CTRL:       rd_val = {29'h0, st_r.ctrl};
         ADDR_STATUS:     rd_val = {28'h0,
                                    (st_r.pwr_st == PWR_UP) || (st_r.pwr_st == PWR_DOWN),
                                    st_r.ctrl[C_PWM], st_r.pwr_act, st_r.run};
         default:         rd_val = 32'h0;
      endcase
      st_nxt.rdata = rd_in ? rd_val : 32'h0;

      //----------------------------------------------------------------
      // pixel clock divider
      //----------------------------------------------------------------
      tick = (st_r.div_cnt == 9'(divider) + DIV_EXTRA - 9'h001);
      st_nxt.div_cnt = tick ? 9'h000 : st_r.div_cnt + 9'h001;
      st_nxt.pclk = (st_nxt.div_cnt < ((9'(divider) + DIV_EXTRA) >> 1));

      //----------------------------------------------------------------
      // position counters
      //----------------------------------------------------------------
      h_last    = (st_r.hpos == htot - 12'h001);
      frame_end = tick && st_r.run && h_last && (st_r.vpos == vtot - 12'h001);
      h_n   = st_r.hpos;
      v_n   = st_r.vpos;
      run_n = st_r.run;
      if (tick)
      begin
         if (!st_r.run)
         begin
            run_n = st_r.ctrl[C_SYNC];
            h_n   = 12'h000;
            v_n   = 12'h000;
         end
         else if (frame_end)
         begin
            run_n = st_r.ctrl[C_SYNC];
            h_n   = 12'h000;
            v_n   = 12'h000;
         end
         else if (h_last)
         begin
            h_n = 12'h000;
            v_n = st_r.vpos + 12'h001;
         end
         else
         begin
            h_n = st_r.hpos + 12'h001;
         end
      end
      st_nxt.hpos = h_n;
      st_nxt.vpos = v_n;
      st_nxt.run  = run_n;
      frame_start = tick && run_n && (h_n == 12'h000) && (v_n == 12'h000);
      edge2_now   = tick && run_n && (h_n == h_edge2);

      //----------------------------------------------------------------
      // sync pulses
      //----------------------------------------------------------------
      // setup with first-edge start lands on the last pixel of the previous
      // frame, so the very first frame after start-up lacks that pulse
      if (st_r.polout[F_VSSU])
      begin
         if (st_r.polout[F_VSALS])
            vs_start = (v_n == vtot - 12'h001) && (h_n == htot - 12'h001);
         else
            vs_start = (v_n == 12'h000) && (h_n == 12'(hsw));
      end
      else
      begin
         vs_start = (v_n == 12'h000) &&
                    (h_n == (st_r.polout[F_VSALS] ? 12'h000 : h_edge2));
      end
      vs_end_pos = (st_r.polout[F_VSALE] ? 12'h000 : h_edge2)
                 + {11'h000, st_r.polout[F_VSHO]};
      vs_end = (v_n == 12'(vsw) + 12'h001) && (h_n == vs_end_pos);
      if (tick)
      begin
         if (!run_n)
            st_nxt.vs_act = 1'b0;
         else if (vs_start)
            st_nxt.vs_act = 1'b1;
         else if (vs_end)
            st_nxt.vs_act = 1'b0;
         st_nxt.hs_o = (run_n && (h_n <= 12'(hsw))) ^ st_r.polout[F_HSYNC_POLARITY];
         st_nxt.de_o = run_n && (h_n >= h_act0) && (h_n <= h_act1) &&
                       (v_n >= v_act0) && (v_n <= v_act1);
      end
      else
      begin
         st_nxt.hs_o = st_r.hs_o;
         st_nxt.de_o = st_r.de_o;
      end
      st_nxt.vs_o = st_nxt.vs_act ^ st_r.polout[F_VSYNC_POLARITY];

      //----------------------------------------------------------------
      // pixel format and dithering
      //----------------------------------------------------------------
      dpat = {h_n[0] ^ v_n[0], v_n[0]};
      rr = pixel_in[23:16];
      gg = pixel_in[15:8];
      bb = pixel_in[7:0];
      if (st_r.polout[F_DITHER])
      begin
         unique case (depth)
            DEPTH_12:
            begin
               rr = lcdtg_dith(pixel_in[23:16], dpat, 4);
               gg = lcdtg_dith(pixel_in[15:8], dpat, 4);
               bb = lcdtg_dith(pixel_in[7:0], dpat, 4);
            end
            DEPTH_16:
            begin
               rr = lcdtg_dith(pixel_in[23:16], dpat, 3);
               gg = lcdtg_dith(pixel_in[15:8], dpat, 2);
               bb = lcdtg_dith(pixel_in[7:0], dpat, 3);
            end
            DEPTH_18:
            begin
               rr = lcdtg_dith(pixel_in[23:16], dpat, 2);
               gg = lcdtg_dith(pixel_in[15:8], dpat, 2);
               bb = lcdtg_dith(pixel_in[7:0], dpat, 2);
            end
            DEPTH_24:
            begin
               rr = pixel_in[23:16];
            end
         endcase
      end
      unique case (depth)
         DEPTH_12: fmt = {12'h000, rr[7:4], gg[7:4], bb[7:4]};
         DEPTH_16: fmt = {8'h00, rr[7:3], gg[7:2], bb[7:3]};
         DEPTH_18: fmt = {6'h00, rr[7:2], gg[7:2], bb[7:2]};
         DEPTH_24: fmt = {rr, gg, bb};
      endcase
      if (tick)
         st_nxt.pix_o = st_nxt.de_o ? fmt : 24'h000000;

      //----------------------------------------------------------------
      // panel power sequencing
      //----------------------------------------------------------------
      unique case (st_r.pwr_st)
         PWR_OFF:
         begin
            st_nxt.guard_cnt = 5'h00;
            if (st_r.ctrl[C_POWER] && st_r.run)
               st_nxt.pwr_st = PWR_UP;
         end
         PWR_UP:
         begin
            if (!st_r.ctrl[C_POWER] || !st_r.run)
               st_nxt.pwr_st = PWR_OFF;
            else if (st_r.guard_cnt == guard)
            begin
               if (st_r.polout[F_PWRALIGN] || edge2_now)
               begin
                  st_nxt.pwr_st  = PWR_ON;
                  st_nxt.pwr_act = 1'b1;
               end
            end
            else if (frame_start)
               st_nxt.guard_cnt = st_r.guard_cnt + 5'h01;
         end
         PWR_ON:
         begin
            if (!st_r.ctrl[C_POWER])
            begin
               st_nxt.pwr_st    = PWR_DOWN;
               st_nxt.pwr_act   = 1'b0;
               st_nxt.guard_cnt = 5'h00;
            end
         end
         PWR_DOWN:
         begin
            // a stopped timing engine has no frames left to wait for
            if ((st_r.guard_cnt == guard) || !st_r.run)
               st_nxt.pwr_st = PWR_OFF;
            else if (frame_start)
               st_nxt.guard_cnt = st_r.guard_cnt + 5'h01;
         end
      endcase
      st_nxt.pwr_o = st_nxt.pwr_act ^ st_r.polout[F_PWRPOL];

      //----------------------------------------------------------------
      // contrast pwm
      //----------------------------------------------------------------
      st_nxt.slow_q = slow_clk_in;
      pwm_tick_src = pwm_src ? 1'b1 : (slow_clk_in && !st_r.slow_q);
      ps_eff   = (ps > PS_MAX) ? PS_MAX : ps;
      pre_mask = 6'((7'h01 << ps_eff) - 7'h01);
      below    = (st_r.pwm_cnt < cval);
      if (!st_r.ctrl[C_PWM])
      begin
         st_nxt.pre_cnt = 6'h00;
         st_nxt.pwm_cnt = 8'h00;
         st_nxt.pwm_o   = 1'b0;
      end
      else
      begin
         if (pwm_tick_src)
         begin
            st_nxt.pre_cnt = st_r.pre_cnt + 6'h01;
            if ((st_r.pre_cnt & pre_mask) == pre_mask)
               st_nxt.pwm_cnt = st_r.pwm_cnt + 8'h01;
         end
         st_nxt.pwm_o = st_r.pwm[F_CONTRAST_POLARITY] ? below : !below;
      end
   end

   //----------------------------------------------------------------
   // registers
   //----------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (!rstn_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   assign rdata_out        = st_r.rdata;
   assign pixel_clock_out  = st_r.pclk;
   assign line_sync_out    = st_r.hs_o;
   assign frame_sync_out   = st_r.vs_o;
   assign data_enable_out  = st_r.de_o;
   assign pixel_data_out   = st_r.pix_o;
   assign panel_power_out  = st_r.pwr_o;
   assign contrast_pwm_out = st_r.pwm_o;

endmodule // lcdtg_top
`default_nettype wire

// ===== testbench/lcdtg_panel.sv
// panel model measuring line and frame timing
`timescale 1ns/1ps
`default_nettype none
module lcdtg_panel
(
   input  wire logic pclk_in,
   input  wire logic hs_in,
   input  wire logic vs_in,
   input  wire logic de_in,
   output var int    hs_len_out,
   output var int    bp_len_out,
   output var int    de_len_out,
   output var int    fp_len_out,
   output var int    rows_out,
   output var int    lines_out,
   output var int    vs_lines_out
);
   int c = 0, r = 0, l = 0, v = 0;
   logic hq = 1'b0, dq = 1'b0, vq = 1'b0, dl = 1'b0;
   // sampled mid pixel, where the outputs have long settled
   always @(negedge pclk_in)
   begin
      c = c + 1;
      if (hs_in && !hq) begin if (dl) fp_len_out <= c; dl = 0; c = 0; l++; v += vs_in; end
      if (!hs_in && hq) begin hs_len_out <= c; c = 0; end
      if (de_in && !dq) begin bp_len_out <= c; c = 0; r++; dl = 1; end
      if (!de_in && dq) begin de_len_out <= c; c = 0; end
      if (vs_in && !vq) begin rows_out <= r; lines_out <= l; vs_lines_out <= v; r = 0; l = 0; v = 0; end
      {hq, dq, vq} = {hs_in, de_in, vs_in};
   end
endmodule // lcdtg_panel
`default_nettype wire

// ===== testbench/lcdtg_props.sv
// port checker of the panel timing block
`timescale 1ns/1ps
`default_nettype none
module lcdtg_props
   import lcdtg_pkg::*;
(
   input wire logic        clk_sys_in,
   input wire logic        rstn_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        pixel_clock_out,
   input wire logic        line_sync_out,
   input wire logic        frame_sync_out,
   input wire logic        data_enable_out,
   input wire logic [23:0] pixel_data_out
);
   // the polout shadow lets sync activity be judged against the polarity in force, the pwm shadow backs the readback check
   logic [31:0] pol_r;
   logic [31:0] pwm_r;
   always_ff @(posedge clk_sys_in)
      if (!rstn_in) {pol_r, pwm_r} <= '0;
      else if (wr_in && addr_in == ADDR_POLOUT) pol_r <= wdata_in & MASK_POLOUT;
      else if (wr_in && addr_in == ADDR_PWM) pwm_r <= wdata_in & MASK_PWM;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   a_rdata_idle:
      assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("stray read data");
   a_unmapped_zero:
      assert property ($past(rd_in) && $past(addr_in) == 32'hF803801C |-> rdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_cval_readback:
      assert property ($past(rd_in) && $past(addr_in) == ADDR_PWM |-> rdata_out == pwm_r)
      else $error("contrast register readback wrong");
   a_de_on_tick:
      assert property ($changed(data_enable_out) |-> $rose(pixel_clock_out))
      else $error("enable moved off a pixel tick");
   a_hs_on_tick:
      assert property ($changed(line_sync_out) && !$past(wr_in) |-> $rose(pixel_clock_out))
      else $error("line sync moved off a pixel tick");
   a_blank_data:
      assert property (!data_enable_out |-> pixel_data_out == 24'h0) else $error("data in blank");
   a_hs_no_de:
      assert property ((line_sync_out ^ pol_r[F_HSYNC_POLARITY]) |-> !data_enable_out)
      else $error("pixels during line sync");
   a_vs_no_de:
      assert property ((frame_sync_out ^ pol_r[F_VSYNC_POLARITY]) |-> !data_enable_out)
      else $error("pixels during frame sync");
   c_active: cover property ($rose(data_enable_out));
   c_frame: cover property ($rose(frame_sync_out));
   c_read: cover property ($past(rd_in) && rdata_out != 32'h0);
endmodule // lcdtg_props
bind lcdtg_top lcdtg_props lcdtg_props_i (.clk_sys_in, .rstn_in, .addr_in, .wdata_in, .wr_in,
   .rd_in, .rdata_out, .pixel_clock_out, .line_sync_out, .frame_sync_out, .data_enable_out,
   .pixel_data_out);
`default_nettype wire

// ===== testbench/test_lcdtg_top.sv
// testbench of the panel timing block
`timescale 1ns/1ps
`default_nettype none
module test_lcdtg_top
   import lcdtg_pkg::*;
;
   logic clk_sys_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, slow_clk_in = 1'b0;
   logic [31:0] addr_in = '0, wdata_in = '0, rdata_out, d;
   logic [23:0] pixel_in = 24'hA5C33C, pixel_data_out;
   logic pixel_clock_out, line_sync_out, frame_sync_out, data_enable_out;
   logic panel_power_out, contrast_pwm_out;
   int failures = 0, tests_run = 0, cycles = 0, hp, hc;
   int hs_len, bp_len, de_len, fp_len, rows, lines, vs_lines;
   logic [31:0] adr [7] = '{ADDR_CLOCK_CFG, ADDR_SYNC_WIDTH, ADDR_VPORCH, ADDR_HPORCH,
      ADDR_AREA, ADDR_POLOUT, ADDR_PWM};
   logic [31:0] val [7] = '{32'hFF020008, 32'hFF010002, 32'hFF020001, 32'hFF010003,
      32'hF8030007, 32'hFFE10301, 32'hFFFF4010};
   logic [31:0] msk [7] = '{MASK_CLOCK_CFG, MASK_SYNC_WIDTH, MASK_VPORCH, MASK_HPORCH,
      MASK_AREA, MASK_POLOUT, MASK_PWM};
   logic [23:0] fmt [4] = '{24'h000AC3, 24'h00A607, 24'h029C0F, 24'hA5C33C};
   lcdtg_top lcdtg_top_i (.clk_sys_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .slow_clk_in, .pixel_in, .pixel_clock_out, .line_sync_out, .frame_sync_out,
      .data_enable_out, .pixel_data_out, .panel_power_out, .contrast_pwm_out);
   // line sync is active low here, the panel wants it active high
   lcdtg_panel lcdtg_panel_i (.pclk_in(pixel_clock_out), .hs_in(!line_sync_out),
      .vs_in(frame_sync_out), .de_in(data_enable_out), .hs_len_out(hs_len),
      .bp_len_out(bp_len), .de_len_out(de_len), .fp_len_out(fp_len), .rows_out(rows),
      .lines_out(lines), .vs_lines_out(vs_lines));
   always #10 clk_sys_in = ~clk_sys_in;
   task automatic end_of_test;
      if (failures == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // slow clock of 16 system cycles, also the hang limit
   always @(posedge clk_sys_in)
   begin
      cycles <= cycles + 1;
      slow_clk_in <= cycles[3];
      if (cycles == 90000) begin failures++; end_of_test(); end
   end
   task automatic wr(input logic [31:0] a, input logic [31:0] x);
      @(posedge clk_sys_in); addr_in <= a; wdata_in <= x; wr_in <= 1'b1;
      @(posedge clk_sys_in); wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] x);
      @(posedge clk_sys_in); addr_in <= a; rd_in <= 1'b1;
      @(posedge clk_sys_in); rd_in <= 1'b0;
      @(negedge clk_sys_in); x = rdata_out;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin failures++; $display("unexpected %s: expected %h seen %h", s, e, g); end
   endtask
   task automatic wait_de;
      while (data_enable_out !== 1'b0) @(posedge clk_sys_in);
      while (data_enable_out !== 1'b1) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask
   task automatic measure(input int w);
      hp = 0; hc = 0;
      // let the new setting reach the output before the first sample
      @(posedge clk_sys_in);
      repeat (w) begin @(negedge clk_sys_in); hp += (contrast_pwm_out === 1'b1);
         hc += (pixel_clock_out === 1'b1); end
   endtask
   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      for (int i = 0; i < 7; i++) wr(adr[i], val[i]);
      for (int i = 0; i < 7; i++) begin rd(adr[i], d); chk("reg", val[i] & msk[i], d); end
      rd(32'hF803801C, d); chk("unmapped", 32'h0, d);
      wr(ADDR_CTRL, 32'h7);
      chk("power early", 32'h0, panel_power_out);
      // one frame is 10 lines of 17 pixels of 4 system cycles
      repeat (2100) @(posedge clk_sys_in);
      chk("power on", 32'h1, panel_power_out);
      chk("hsync", 32'd3, hs_len);
      chk("back porch", 32'd2, bp_len);
      chk("pixels", 32'd8, de_len);
      chk("front porch", 32'd4, fp_len);
      chk("rows", 32'd4, rows);
      chk("lines", 32'd10, lines);
      chk("vsync", 32'd2, vs_lines);
      for (int i = 0; i < 4; i++) begin wr(ADDR_POLOUT, 32'h00010011 | (i << 8)); wait_de();
         chk("pixel", fmt[i], pixel_data_out); end
      // first pixel of a line sits on an odd column, so its pattern step is never zero
      wr(ADDR_POLOUT, 32'h00010051); pixel_in <= 24'hECECEC; wait_de();
      chk("dither", 24'h000FFF, pixel_data_out);
      chk("power pol", 32'h0, panel_power_out);
      for (int p = 0; p < 7; p++) begin wr(ADDR_PWM, 32'h4000 | (p[0] << 4) | p); measure(512 << p);
         chk("pwm", p[0] ? 128 << p : 384 << p, hp); end
      chk("pixel clock", 32'd16384, hc);
      wr(ADDR_CLOCK_CFG, 32'h00020000); wr(ADDR_PWM, 32'h4010); measure(8192);
      chk("slow pwm", 32'd2048, hp);
      // start inside an active line so no frame start falls before the status read
      wait_de(); wr(ADDR_CTRL, 32'h5); repeat (3) @(posedge clk_sys_in);
      chk("power off", 32'h1, panel_power_out);
      rd(ADDR_STATUS, d); chk("guard busy", 32'h1, d[3]);
      wait_de(); wr(ADDR_CTRL, 32'h4); repeat (8) @(negedge clk_sys_in);
      chk("frame end", 32'h1, data_enable_out);
      repeat (1400) @(posedge clk_sys_in); rd(ADDR_STATUS, d);
      chk("sync off", 32'h0, d[0]);
      end_of_test();
   end
endmodule // test_lcdtg_top
`default_nettype wire
